//--- eivc_top.v
// Interrupt front end: external lines, pin-change groups, vector control register
`default_nettype none
module eivc_top (
  input wire mclk,
  input wire reset_n,
  input wire [7:0] busAddr,
  input wire busIoSpace,
  input wire busWr,
  input wire busRd,
  input wire [7:0] busWrData,
  input wire instrDone,
  input wire globalIrqEnable,
  input wire execInBoot,
  input wire bootLockAppRule,
  input wire bootLockBootRule,
  input wire debugPortFuseEnable,
  input wire [15:0] bootSizeStart,
  input wire [2:0] extIrqPin,
  input wire [31:0] pinChangeInput,
  input wire [2:0] irqAck,
  input wire [3:0] pcAck,
  output reg [7:0] busRdData_r,
  output reg [15:0] vectorBase_r,
  output reg debugPortEnable_r,
  output reg pullupDisable_r,
  output reg [2:0] extIrqReq_r,
  output reg [3:0] pcReq_r,
  output reg wakeReq_r
);
`include "eivc_map.vh"
  reg [7:0] mcuCtrl_r;
  reg [7:0] senseCtrl_r;
  reg [2:0] irqMask_r;
  reg [3:0] pcCtrl_r;
  reg [7:0] pcMask_r [0:3];
  reg [2:0] unlockCnt_r;
  reg blockPend_r;
  reg blockHold_r;
  reg [2:0] jtdCnt_r;
  reg jtdVal_r;
  reg [31:0] pcPrev_r;
  reg [3:0] pcFlag_r;
  reg [7:0] effAddr;
  reg selMcu, selSense, selFlags, selMask, selPcCtrl, selPcMask;
  reg [1:0] pcIdx;
  reg [7:0] pcOff;
  reg [7:0] rdMux;
  wire [2:0] lineFlag;
  wire [2:0] lineLevel;
  wire [2:0] lineLowAsync;
  wire unlockActive;
  wire sectionBlock;
  wire irqBlock;
  wire wrMcu;
  wire [3:0] pcToggle;
  integer k;
  integer j;
  // Short I/O addresses are offset; extended space refuses them
  always @* begin
    effAddr = busIoSpace ? busAddr + `EIVC_IO_OFFSET : busAddr;
    selMcu = (effAddr == `EIVC_MCU_CONTROL_ADDR);
    selFlags = (effAddr == `EIVC_IRQ_FLAGS_ADDR);
    selMask = (effAddr == `EIVC_IRQ_MASK_ADDR);
    selSense = !busIoSpace && (effAddr == `EIVC_SENSE_CTRL_ADDR);
    selPcCtrl = !busIoSpace && (effAddr == `EIVC_PC_CTRL_ADDR);
    selPcMask = !busIoSpace && (effAddr >= `EIVC_PC_MASK0_ADDR) &&
      (effAddr < `EIVC_PC_MASK0_ADDR + 8'h04);
    pcOff = effAddr - `EIVC_PC_MASK0_ADDR;
    pcIdx = pcOff[1:0];
    if (busIoSpace && busAddr >= `EIVC_IO_OFFSET + `EIVC_IO_OFFSET) begin
      selMcu = 1'b0;
      selFlags = 1'b0;
      selMask = 1'b0;
    end
  end
  assign wrMcu = busWr & selMcu;
  genvar g;
  generate
    for (g = 0; g < 3; g = g + 1) begin : gLine
      eivc_line uLine (
        .mclk(mclk),
        .reset_n(reset_n),
        .pinIn(extIrqPin[g]),
        .sense(senseCtrl_r[2*g+1:2*g]),
        .flagClr((busWr & selFlags & busWrData[g]) | irqAck[g]),
        .flag_r(lineFlag[g]),
        .levelReq(lineLevel[g]),
        .lowAsync(lineLowAsync[g])
      );
    end
  endgenerate
  assign unlockActive = mcuCtrl_r[`EIVC_BIT_UNLOCK];
  // Pending block lasts until the instruction after the select write
  assign irqBlock = unlockActive | blockPend_r | blockHold_r;
  assign sectionBlock = (mcuCtrl_r[`EIVC_BIT_VSEL] & !execInBoot & bootLockAppRule) |
    (!mcuCtrl_r[`EIVC_BIT_VSEL] & execInBoot & bootLockBootRule);
  always @(posedge mclk) begin
    if (!reset_n) begin
      mcuCtrl_r <= `EIVC_MCU_CONTROL_RESET;
      unlockCnt_r <= 3'h0;
      blockPend_r <= 1'b0;
      blockHold_r <= 1'b0;
      jtdCnt_r <= 3'h0;
      jtdVal_r <= 1'b0;
    end else begin
      if (wrMcu) begin
        mcuCtrl_r[`EIVC_BIT_PUD] <= busWrData[`EIVC_BIT_PUD];
      end
      if (wrMcu && busWrData[`EIVC_BIT_UNLOCK] && !unlockActive) begin
        mcuCtrl_r[`EIVC_BIT_UNLOCK] <= 1'b1;
        unlockCnt_r <= `EIVC_WINDOW_CYCLES - 3'h1;
      end else if (wrMcu && unlockActive) begin
        mcuCtrl_r[`EIVC_BIT_VSEL] <= busWrData[`EIVC_BIT_VSEL];
        mcuCtrl_r[`EIVC_BIT_UNLOCK] <= 1'b0;
        unlockCnt_r <= 3'h0;
        blockPend_r <= 1'b1;
      end else if (unlockActive) begin
        if (unlockCnt_r == 3'h1) begin
          mcuCtrl_r[`EIVC_BIT_UNLOCK] <= 1'b0;
        end
        unlockCnt_r <= unlockCnt_r - 3'h1;
      end
      if (blockPend_r && instrDone) begin
        blockPend_r <= 1'b0;
        blockHold_r <= 1'b1;
      end else if (blockHold_r && instrDone) begin
        blockHold_r <= 1'b0;
      end
      // Debug disable needs the same value written twice inside the window
      if (wrMcu) begin
        if (jtdCnt_r != 3'h0 && busWrData[`EIVC_BIT_JTD] == jtdVal_r) begin
          mcuCtrl_r[`EIVC_BIT_JTD] <= jtdVal_r;
          jtdCnt_r <= 3'h0;
        end else begin
          jtdVal_r <= busWrData[`EIVC_BIT_JTD];
          jtdCnt_r <= `EIVC_WINDOW_CYCLES;
        end
      end else if (jtdCnt_r != 3'h0) begin
        jtdCnt_r <= jtdCnt_r - 3'h1;
      end
    end
  end
  always @(posedge mclk) begin
    if (!reset_n) begin
      senseCtrl_r <= `EIVC_SENSE_CTRL_RESET;
      irqMask_r <= 3'h0;
      pcCtrl_r <= 4'h0;
      for (k = 0; k < 4; k = k + 1) begin
        pcMask_r[k] <= 8'h00;
      end
    end else if (busWr) begin
      if (selSense) begin
        senseCtrl_r <= busWrData & `EIVC_SENSE_CTRL_MASK;
      end
      if (selMask) begin
        irqMask_r <= busWrData[2:0];
      end
      if (selPcCtrl) begin
        pcCtrl_r <= busWrData[3:0];
      end
      if (selPcMask) begin
        pcMask_r[pcIdx] <= busWrData;
      end
    end
  end
  genvar p;
  generate
    for (p = 0; p < 4; p = p + 1) begin : gPc
      assign pcToggle[p] = |((pinChangeInput[8*p+7:8*p] ^ pcPrev_r[8*p+7:8*p]) &
        pcMask_r[p]);
    end
  endgenerate
  always @(posedge mclk) begin
    if (!reset_n) begin
      pcPrev_r <= 32'h0000_0000;
      pcFlag_r <= 4'h0;
    end else begin
      pcPrev_r <= pinChangeInput;
      for (j = 0; j < 4; j = j + 1) begin
        if (pcToggle[j]) begin
          pcFlag_r[j] <= 1'b1;
        end else if (pcAck[j]) begin
          pcFlag_r[j] <= 1'b0;
        end
      end
    end
  end
  always @* begin
    rdMux = 8'h00;
    if (selMcu) rdMux = mcuCtrl_r & `EIVC_MCU_CONTROL_MASK;
    if (selSense) rdMux = senseCtrl_r;
    if (selFlags) rdMux = {5'h00, lineFlag};
    if (selMask) rdMux = {5'h00, irqMask_r};
    if (selPcCtrl) rdMux = {4'h0, pcCtrl_r};
    if (selPcMask) rdMux = pcMask_r[pcIdx];
  end
  always @(posedge mclk) begin
    if (!reset_n) begin
      busRdData_r <= 8'h00;
      vectorBase_r <= 16'h0000;
      debugPortEnable_r <= 1'b0;
      pullupDisable_r <= 1'b0;
      extIrqReq_r <= 3'h0;
      pcReq_r <= 4'h0;
      wakeReq_r <= 1'b0;
    end else begin
      busRdData_r <= busRd ? rdMux : 8'h00;
      vectorBase_r <= mcuCtrl_r[`EIVC_BIT_VSEL] ? bootSizeStart : 16'h0000;
      debugPortEnable_r <= !mcuCtrl_r[`EIVC_BIT_JTD] & debugPortFuseEnable;
      pullupDisable_r <= mcuCtrl_r[`EIVC_BIT_PUD];
      extIrqReq_r <= (lineFlag | lineLevel) & irqMask_r &
        {3{globalIrqEnable & !irqBlock & !sectionBlock}};
      pcReq_r <= pcFlag_r & pcCtrl_r &
        {4{globalIrqEnable & !irqBlock & !sectionBlock}};
      // Wake-up request; a level gone before start-up leaves no flag behind
      wakeReq_r <= |(lineLowAsync & irqMask_r) | |(pcToggle & pcCtrl_r);
    end
  end
endmodule // eivc_top
`default_nettype wire

//--- eivc_map.vh
// Register offsets, field positions, reset values and timing counts for the interrupt front end
`ifndef EIVC_MAP_VH
`define EIVC_MAP_VH
`define EIVC_IO_OFFSET 8'h20
`define EIVC_EXT_IO_BASE 8'h60
`define EIVC_MCU_CONTROL_ADDR 8'h55
`define EIVC_MCU_CONTROL_IO 8'h35
`define EIVC_SENSE_CTRL_ADDR 8'h69
`define EIVC_IRQ_FLAGS_ADDR 8'h3C
`define EIVC_IRQ_MASK_ADDR 8'h3D
`define EIVC_PC_CTRL_ADDR 8'h68
`define EIVC_PC_MASK0_ADDR 8'h6B
`define EIVC_MCU_CONTROL_RESET 8'h00
`define EIVC_SENSE_CTRL_RESET 8'h00
`define EIVC_MCU_CONTROL_MASK 8'h93
`define EIVC_SENSE_CTRL_MASK 8'h3F
`define EIVC_BIT_UNLOCK 0
`define EIVC_BIT_VSEL 1
`define EIVC_BIT_PUD 4
`define EIVC_BIT_JTD 7
`define EIVC_SENSE_LOW 2'h0
`define EIVC_SENSE_ANY 2'h1
`define EIVC_SENSE_FALL 2'h2
`define EIVC_SENSE_RISE 2'h3
`define EIVC_WINDOW_CYCLES 3'h4
`endif

//--- eivc_line.v
// One external interrupt line: sync, edge/level decode and sticky flag
`default_nettype none
module eivc_line (
  input wire mclk,
  input wire reset_n,
  input wire pinIn,
  input wire [1:0] sense,
  input wire flagClr,
  output reg flag_r,
  output wire levelReq,
  output wire lowAsync
);
`include "eivc_map.vh"
  reg sync1_r;
  reg sync2_r;
  reg prev_r;
  reg trig;
  always @(posedge mclk) begin
    if (!reset_n) begin
      sync1_r <= 1'b1;
      sync2_r <= 1'b1;
      prev_r <= 1'b1;
    end else begin
      sync1_r <= pinIn;
      sync2_r <= sync1_r;
      prev_r <= sync2_r;
    end
  end
  always @* begin
    case (sense)
      `EIVC_SENSE_ANY: trig = sync2_r ^ prev_r;
      `EIVC_SENSE_FALL: trig = prev_r & ~sync2_r;
      `EIVC_SENSE_RISE: trig = ~prev_r & sync2_r;
      default: trig = 1'b0;
    endcase
  end
  always @(posedge mclk) begin
    if (!reset_n) begin
      flag_r <= 1'b0;
    end else if (sense == `EIVC_SENSE_LOW) begin
      flag_r <= 1'b0;
    end else if (trig) begin
      flag_r <= 1'b1; // set wins over clear
    end else if (flagClr) begin
      flag_r <= 1'b0;
    end
  end
  assign levelReq = (sense == `EIVC_SENSE_LOW) & ~sync2_r;
  assign lowAsync = (sense == `EIVC_SENSE_LOW) & ~pinIn;
endmodule // eivc_line
`default_nettype wire

//--- eivc_asserts.sv
// Concurrent checks on the ports of the interrupt front end
`default_nettype none
module eivc_asserts (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic [7:0] busAddr,
  input wire logic busIoSpace,
  input wire logic busWr,
  input wire logic busRd,
  input wire logic [7:0] busWrData,
  input wire logic globalIrqEnable,
  input wire logic execInBoot,
  input wire logic bootLockAppRule,
  input wire logic debugPortFuseEnable,
  input wire logic [15:0] bootSizeStart,
  input wire logic [7:0] busRdData_r,
  input wire logic [15:0] vectorBase_r,
  input wire logic debugPortEnable_r,
  input wire logic pullupDisable_r,
  input wire logic [2:0] extIrqReq_r,
  input wire logic [3:0] pcReq_r
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!reset_n);
  wire logic mcuWr = busWr && (busIoSpace ? busAddr == 8'h35 : busAddr == 8'h55);
  wire logic anyReq = (extIrqReq_r != 3'h0) || (pcReq_r != 4'h0);
  wire logic lockBlk = (vectorBase_r != 16'h0000) && !execInBoot && bootLockAppRule;
  a_rd_idle_zero: assert property (!$past(busRd) |-> busRdData_r == 8'h00)
    else $error("read data not zero when idle");
  a_io_ext_zero: assert property (
    $past(busRd && busIoSpace && busAddr[7:6] != 2'h0) |-> busRdData_r == 8'h00)
    else $error("extended register reached by short access");
  a_vec_base_val: assert property (vectorBase_r == 16'h0000 || vectorBase_r == bootSizeStart)
    else $error("vector base neither zero nor boot start");
  a_vec_needs_wr: assert property ($changed(vectorBase_r) |-> $past(mcuWr, 2))
    else $error("vector base moved without a control write");
  a_pud_follows: assert property (mcuWr |-> ##2 pullupDisable_r == $past(busWrData[4], 2))
    else $error("pull-up disable does not follow write");
  a_dbg_fuse_off: assert property (!$past(debugPortFuseEnable) |-> !debugPortEnable_r)
    else $error("debug port on without fuse");
  a_req_gie: assert property (anyReq |-> $past(globalIrqEnable))
    else $error("request without global enable");
  a_unlock_block: assert property (mcuWr && busWrData[0] |-> ##2 !anyReq [*3])
    else $error("request during unlock window");
  a_lock_block: assert property (lockBlk && $past(lockBlk) |-> !anyReq)
    else $error("request while boot lock blocks");
  c_unlock: cover property (mcuWr && busWrData[0]);
  c_vec_move: cover property ($rose(vectorBase_r != 16'h0000));
  c_pc_req: cover property (pcReq_r != 4'h0);
endmodule // eivc_asserts
bind eivc_top eivc_asserts chk (.mclk, .reset_n, .busAddr, .busIoSpace, .busWr, .busRd,
  .busWrData, .globalIrqEnable, .execInBoot, .bootLockAppRule, .debugPortFuseEnable,
  .bootSizeStart, .busRdData_r, .vectorBase_r, .debugPortEnable_r, .pullupDisable_r,
  .extIrqReq_r, .pcReq_r);
`default_nettype wire

//--- eivc_pin_model.sv
// Behavioural driver of the external and pin-change pins
`default_nettype none
module eivc_pin_model (
  input wire logic mclk,
  output var logic [2:0] extIrqPin,
  output var logic [31:0] pinChangeInput
);
  timeunit 1ns;
  timeprecision 100ps;
  initial extIrqPin = 3'h7;
  initial pinChangeInput = 32'h0000_0000;
  // Level is driven, then held for hold clock cycles before the task returns
  task automatic drive(input int line, input logic v, input int hold);
    @(posedge mclk);
    #2 extIrqPin[line] = v;
    repeat (hold) @(posedge mclk);
    #2;
  endtask
  task automatic toggle(input int idx);
    @(posedge mclk);
    #2 pinChangeInput[idx] = ~pinChangeInput[idx];
  endtask
endmodule // eivc_pin_model
`default_nettype wire

//--- eivc_top_tb_top.sv
// Self-checking testbench of the interrupt front end
`default_nettype none
module eivc_top_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic mclk = 0, reset_n = 0, busIoSpace = 0, busWr = 0, busRd = 0, instrDone = 0;
  logic gie = 1, execInBoot = 1, lockApp = 1, lockBoot = 0, fuseEn = 1, dbgEn, pudOut, wake;
  logic [7:0] busAddr = 8'h00, busWrData = 8'h00, rdData;
  logic [2:0] irqAck = 3'h0, extIrqPin, extReq;
  logic [3:0] pcAck = 4'h0, pcReq;
  logic [31:0] pcIn;
  logic [15:0] vecBase;
  localparam logic [15:0] BootStart = 16'h1F00;
  int n_fail = 0, n_tests = 0;
  eivc_top uut (.mclk, .reset_n, .busAddr, .busIoSpace, .busWr, .busRd, .busWrData,
    .instrDone, .globalIrqEnable(gie), .execInBoot, .bootLockAppRule(lockApp),
    .bootLockBootRule(lockBoot), .debugPortFuseEnable(fuseEn), .bootSizeStart(BootStart),
    .extIrqPin, .pinChangeInput(pcIn), .irqAck, .pcAck, .busRdData_r(rdData),
    .vectorBase_r(vecBase), .debugPortEnable_r(dbgEn), .pullupDisable_r(pudOut),
    .extIrqReq_r(extReq), .pcReq_r(pcReq), .wakeReq_r(wake));
  eivc_pin_model pins (.mclk, .extIrqPin, .pinChangeInput(pcIn));
  initial forever #12.5 mclk = ~mclk;
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #2;
  endtask
  task automatic wr(input logic [7:0] a, input logic io, input logic [7:0] d);
    tick(1);
    busAddr = a;
    busIoSpace = io;
    busWrData = d;
    busWr = 1;
    tick(1);
    busWr = 0;
  endtask
  task automatic rd(input logic [7:0] a, input logic io, input logic [7:0] exp);
    tick(1);
    busAddr = a;
    busIoSpace = io;
    busRd = 1;
    tick(1);
    busRd = 0;
    chk(rdData, exp);
  endtask
  task automatic ack(input logic [2:0] m);
    irqAck = m;
    tick(1);
    irqAck = 3'h0;
  endtask
  task automatic t_regs;
    rd(8'h55, 0, 8'h00);
    rd(8'h69, 0, 8'h00);
    wr(8'h35, 1, 8'h10);
    tick(1);
    chk(pudOut, 1'h1);
    rd(8'h55, 0, 8'h10);
    wr(8'h69, 0, 8'hFF);
    rd(8'h69, 0, 8'h3F);
    wr(8'h49, 1, 8'h00);
    rd(8'h69, 0, 8'h3F);
    rd(8'h49, 1, 8'h00);
  endtask
  task automatic t_vsel;
    wr(8'h55, 0, 8'h12);
    tick(3);
    chk(vecBase, 16'h0000);
    wr(8'h55, 0, 8'h11);
    wr(8'h55, 0, 8'h12);
    tick(3);
    chk(vecBase, BootStart);
    repeat (2) begin
      instrDone = 1;
      tick(1);
      instrDone = 0;
      tick(1);
    end
    wr(8'h55, 0, 8'h13);
    tick(6);
    wr(8'h55, 0, 8'h10);
    tick(3);
    chk(vecBase, BootStart);
    wr(8'h55, 0, 8'h12);
    rd(8'h55, 0, 8'h12);
  endtask
  task automatic t_dbg;
    fuseEn = 0;
    tick(2);
    chk(dbgEn, 1'h0);
    fuseEn = 1;
    tick(2);
    chk(dbgEn, 1'h1);
    wr(8'h55, 0, 8'h92);
    tick(6);
    chk(dbgEn, 1'h1);
    wr(8'h55, 0, 8'h92);
    wr(8'h55, 0, 8'h92);
    tick(1);
    chk(dbgEn, 1'h0);
  endtask
  task automatic t_edge;
    wr(8'h3D, 0, 8'h07);
    for (int m = 0; m < 4; m++) begin
      wr(8'h69, 0, 8'(m << 2));
      pins.drive(1, 1'h0, 5);
      chk(extReq[1], 1'(m != 3));
      ack(3'h2);
      tick(2);
      chk(extReq[1], 1'(m == 0));
      pins.drive(1, 1'h1, 5);
      chk(extReq[1], 1'(m[0]));
      ack(3'h2);
    end
    wr(8'h69, 0, 8'h08);
    gie = 0;
    pins.drive(1, 1'h0, 5);
    chk(extReq[1], 1'h0);
    gie = 1;
    tick(2);
    chk(extReq[1], 1'h1);
    ack(3'h2);
    wr(8'h69, 0, 8'h28);
    pins.drive(2, 1'h0, 5);
    chk(extReq, 3'h4);
    pins.drive(2, 1'h1, 1);
    ack(3'h4);
  endtask
  task automatic t_pc;
    wr(8'h68, 0, 8'h0F);
    wr(8'h6D, 0, 8'h01);
    pins.toggle(16);
    tick(1);
    chk(wake, 1'h1);
    tick(4);
    chk(pcReq, 4'h4);
    pcAck = 4'h4;
    tick(1);
    pcAck = 4'h0;
    pins.toggle(17);
    tick(5);
    chk(pcReq, 4'h0);
  endtask
  task automatic t_lock;
    wr(8'h69, 0, 8'h00);
    pins.drive(1, 1'h0, 5);
    chk(extReq[1], 1'h1);
    execInBoot = 0;
    tick(3);
    chk(extReq[1], 1'h0);
    execInBoot = 1;
    wr(8'h55, 0, 8'h93);
    tick(1);
    chk(extReq[1], 1'h0);
    tick(6);
    chk(extReq[1], 1'h1);
    pins.drive(1, 1'h1, 1);
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  initial begin
    #100000;
    n_fail++;
    complete_run;
  end
  initial begin
    tick(5);
    reset_n = 1;
    t_regs;
    t_vsel;
    t_dbg;
    t_edge;
    t_pc;
    t_lock;
    complete_run;
  end
endmodule // eivc_top_tb_top
`default_nettype wire
